/* src/sbt_defines.svh */
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

// ****************************************
// clock chain
// ****************************************
`define SBT_XTAL_DIV 4
`define SBT_PRE_DIV0 4'h1
`define SBT_PRE_DIV1 4'h3
`define SBT_PRE_DIV2 4'h4
`define SBT_PRE_DIV3 4'hD
`define SBT_TAP_MAX 3'h7
`define SBT_TAP_ALL 7'h7F
`define SBT_SMP_LAST 4'hF
`define SBT_SMP_MID 4'h7

// ****************************************
// frame
// ****************************************
`define SBT_LEN_SHORT 4'hA
`define SBT_LEN_LONG 4'hB
`define SBT_SHREG_ONES 11'h7FF

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SBT_OFS_CTRL 5'h00
`define SBT_OFS_DATA 5'h04
`define SBT_OFS_STAT 5'h08
`define SBT_OFS_ISTAT 5'h0C
`define SBT_OFS_ICLR 5'h10
`define SBT_OFS_IEN 5'h14

// ****************************************
// control fields
// ****************************************
`define SBT_CTRL_PRE_LO 0
`define SBT_CTRL_PRE_HI 1
`define SBT_CTRL_RATE_LO 2
`define SBT_CTRL_RATE_HI 4
`define SBT_CTRL_TE 5
`define SBT_CTRL_M 6
`define SBT_CTRL_GPIO_OUT 7
`define SBT_CTRL_GPIO_DIR 8

// ****************************************
// reset values
// ****************************************
`define SBT_RST_CTRL 9'h000
`define SBT_RST_HOLD 9'h000
`define SBT_RST_IRQ2 2'h0
`define SBT_RST_RDATA 32'h0000_0000

`endif

/* src/sbt_pkg.sv */
package sbt_pkg;

    typedef enum logic {
        SBT_TX_GPIO,
        SBT_TX_RUN
    } sbt_tx_e;

    typedef struct packed {
        logic [8:0] ctrl;
        logic [8:0] tx_hold;
        logic tx_buffer_empty_flag;
        logic tx_buffer_empty_flag_pend;
        logic tc;
        sbt_tx_e st;
        logic [10:0] shreg;
        logic [3:0] bits_left;
        logic pin_o;
        logic pin_oe;
        logic [1:0] ist;
        logic [1:0] ien;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
    } sbt_core_s;

endpackage

/* src/sbt_baud_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface sbt_baud_if;
    logic [1:0] prescale_sel;
    logic [2:0] rate_tap_select;
    logic bus_tick;
    logic sample_tick;
    logic bit_fall;
    logic bit_rise;

    modport gen (
        input prescale_sel,
        input rate_tap_select,
        output bus_tick,
        output sample_tick,
        output bit_fall,
        output bit_rise
    );

    modport core (
        output prescale_sel,
        output rate_tap_select,
        input bus_tick,
        input sample_tick,
        input bit_fall,
        input bit_rise
    );
endinterface

`default_nettype wire

/* src/sbt_baud_gen.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defines.svh"

module sbt_baud_gen #(
    parameter int XTAL_DIV = `SBT_XTAL_DIV
) (
    input wire logic mclk,
    input wire logic rst_n,
    sbt_baud_if.gen bi
);
    import sbt_pkg::*;

    localparam int BW = (XTAL_DIV > 1) ? $clog2(XTAL_DIV) : 1;
    localparam logic [BW-1:0] BUS_LAST = BW'(XTAL_DIV - 1);

    generate
        if (XTAL_DIV < 1) begin : g_bad
            $error("sbt_baud_gen: XTAL_DIV must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [BW-1:0] bus_cnt;
        logic [3:0] pre_cnt;
        logic [6:0] chain;
        logic [3:0] smp_cnt;
        logic bus_tick;
        logic sample_tick;
        logic bit_fall;
        logic bit_rise;
    } sbt_gen_s;

    sbt_gen_s s_r;
    sbt_gen_s s_nxt;

    function automatic logic [3:0] sbt_pre_div(input logic [1:0] code);
        case (code)
            2'h0: sbt_pre_div = `SBT_PRE_DIV0;
            2'h1: sbt_pre_div = `SBT_PRE_DIV1;
            2'h2: sbt_pre_div = `SBT_PRE_DIV2;
            default: sbt_pre_div = `SBT_PRE_DIV3;
        endcase
    endfunction

    // ****************************************
    // divider chain
    // ****************************************
    always_comb begin
        logic bus_hit;
        logic pre_hit;
        logic smp_hit;
        logic [6:0] mask;
        bus_hit = 1'b0;
        pre_hit = 1'b0;
        smp_hit = 1'b0;
        mask = `SBT_TAP_ALL >> (`SBT_TAP_MAX - bi.rate_tap_select);
        s_nxt = s_r;
        bus_hit = (s_r.bus_cnt == BUS_LAST);
        s_nxt.bus_cnt = bus_hit ? '0 : BW'(s_r.bus_cnt + 1'b1);
        // >= so a prescale change never strands the counter above its limit
        if (bus_hit) begin
            pre_hit = (s_r.pre_cnt >= (sbt_pre_div(bi.prescale_sel) - 4'h1));
            s_nxt.pre_cnt = pre_hit ? 4'h0 : (s_r.pre_cnt + 4'h1);
        end
        if (pre_hit) begin
            s_nxt.chain = s_r.chain + 7'h01;
        end
        smp_hit = pre_hit && ((s_r.chain & mask) == mask);
        if (smp_hit) begin
            s_nxt.smp_cnt = s_r.smp_cnt + 4'h1;
        end
        s_nxt.bus_tick = bus_hit;
        s_nxt.sample_tick = smp_hit;
        s_nxt.bit_fall = smp_hit && (s_r.smp_cnt == `SBT_SMP_LAST);
        s_nxt.bit_rise = smp_hit && (s_r.smp_cnt == `SBT_SMP_MID);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bi.bus_tick = s_r.bus_tick;
    assign bi.sample_tick = s_r.sample_tick;
    assign bi.bit_fall = s_r.bit_fall;
    assign bi.bit_rise = s_r.bit_rise;

    a_fall_on_sample: assert property (@(posedge mclk) disable iff (!rst_n)
        s_r.bit_fall |-> s_r.sample_tick)
        else $error("bit clock edge without sample tick");

endmodule

`default_nettype wire

/* src/sbt_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defines.svh"

module sbt_top #(
    parameter int XTAL_DIV = `SBT_XTAL_DIV
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic shared_gpio_pin_i,
    output logic shared_gpio_pin_o,
    output logic shared_gpio_pin_oe,
    output logic irq
);
    import sbt_pkg::*;

    sbt_baud_if bi ();

    sbt_core_s s_r;
    sbt_core_s s_nxt;

    logic wr_acc;
    logic rd_acc;
    logic xfer;
    logic data_wr;
    logic [3:0] flen;
    logic tx_buffer_empty_flag_evt;
    logic tc_evt;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] sbt_be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be
    );
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        sbt_be_merge = (old_v & ~m) | (new_v & m);
    endfunction

    // ****************************************
    // parameter check
    // ****************************************
    generate
        if (XTAL_DIV < 1) begin : g_bad_div
            $error("sbt_top: XTAL_DIV must be at least 1");
        end
    endgenerate

    // ****************************************
    // clock chain
    // ****************************************
    assign bi.prescale_sel = s_r.ctrl[`SBT_CTRL_PRE_HI:`SBT_CTRL_PRE_LO];
    assign bi.rate_tap_select = s_r.ctrl[`SBT_CTRL_RATE_HI:`SBT_CTRL_RATE_LO];

    sbt_baud_gen #(
        .XTAL_DIV(XTAL_DIV)
    ) u_gen (
        .mclk(mclk),
        .rst_n(rst_n),
        .bi(bi)
    );

    // ****************************************
    // next state
    // ****************************************
    assign wr_acc = avs_write && !s_r.waitreq;
    assign rd_acc = avs_read && s_r.waitreq;
    assign data_wr = wr_acc && (avs_address == `SBT_OFS_DATA);
    assign flen = s_r.ctrl[`SBT_CTRL_M] ? `SBT_LEN_LONG : `SBT_LEN_SHORT;
    // transfers align to the mid-bit edge, so a queued character sits ready
    // in the shifter while the previous stop bit is still on the pin
    assign xfer = bi.bit_rise && (s_r.st == SBT_TX_RUN) && (s_r.bits_left == 4'h0)
        && !s_r.tx_buffer_empty_flag && s_r.ctrl[`SBT_CTRL_TE];

    always_comb begin
        logic [31:0] merge_v;
        merge_v = 32'h0000_0000;
        s_nxt = s_r;
        tx_buffer_empty_flag_evt = 1'b0;
        tc_evt = 1'b0;

        // one wait state on every access, then the answer
        s_nxt.waitreq = !((avs_read || avs_write) && s_r.waitreq);

        // buffer empty follows the transfer by one bus phase tick
        if (s_r.tx_buffer_empty_flag_pend && bi.bus_tick) begin
            s_nxt.tx_buffer_empty_flag = 1'b1;
            s_nxt.tx_buffer_empty_flag_pend = 1'b0;
            tx_buffer_empty_flag_evt = 1'b1;
        end

        case (s_r.st)
            SBT_TX_GPIO: begin
                if (bi.bit_fall && s_r.ctrl[`SBT_CTRL_TE]) begin
                    s_nxt.st = SBT_TX_RUN;
                    s_nxt.shreg = `SBT_SHREG_ONES;
                    s_nxt.bits_left = flen - 4'h1;
                    s_nxt.pin_o = 1'b1;
                    s_nxt.tc = 1'b0;
                end
            end
            SBT_TX_RUN: begin
                if (bi.bit_fall) begin
                    if (s_r.bits_left != 4'h0) begin
                        s_nxt.pin_o = s_r.shreg[0];
                        s_nxt.shreg = {1'b1, s_r.shreg[10:1]};
                        s_nxt.bits_left = s_r.bits_left - 4'h1;
                    end else if (!s_r.ctrl[`SBT_CTRL_TE]) begin
                        s_nxt.st = SBT_TX_GPIO;
                        s_nxt.tc = 1'b1;
                        tc_evt = !s_r.tc;
                    end else begin
                        s_nxt.pin_o = 1'b1;
                        if (s_r.tx_buffer_empty_flag && !s_r.tx_buffer_empty_flag_pend) begin
                            s_nxt.tc = 1'b1;
                            tc_evt = !s_r.tc;
                        end
                    end
                end
                if (xfer) begin
                    // stop bit, data, start bit; unused top bits stay idle high
                    if (s_r.ctrl[`SBT_CTRL_M]) begin
                        s_nxt.shreg = {1'b1, s_r.tx_hold, 1'b0};
                    end else begin
                        s_nxt.shreg = {2'h3, s_r.tx_hold[7:0], 1'b0};
                    end
                    s_nxt.bits_left = flen;
                    s_nxt.tx_buffer_empty_flag_pend = 1'b1;
                    s_nxt.tc = 1'b0;
                end
            end
            default: begin
                s_nxt.st = SBT_TX_GPIO;
            end
        endcase

        // register writes
        if (wr_acc) begin
            case (avs_address)
                `SBT_OFS_CTRL: begin
                    // narrow registers keep only the low lanes of the merged word
                    merge_v = sbt_be_merge({23'h0, s_r.ctrl}, avs_writedata, avs_byteenable);
                    s_nxt.ctrl = merge_v[8:0];
                end
                `SBT_OFS_DATA: begin
                    // a write refills the buffer, so it beats a pending empty flag
                    merge_v = sbt_be_merge({23'h0, s_r.tx_hold}, avs_writedata, avs_byteenable);
                    s_nxt.tx_hold = merge_v[8:0];
                    s_nxt.tx_buffer_empty_flag = 1'b0;
                    s_nxt.tx_buffer_empty_flag_pend = 1'b0;
                end
                `SBT_OFS_ICLR: begin
                    if (avs_byteenable[0]) begin
                        s_nxt.ist = s_r.ist & ~avs_writedata[1:0];
                    end
                end
                `SBT_OFS_IEN: begin
                    merge_v = sbt_be_merge({30'h0, s_r.ien}, avs_writedata, avs_byteenable);
                    s_nxt.ien = merge_v[1:0];
                end
                default: begin
                end
            endcase
        end

        // set wins over a clear in the same cycle
        s_nxt.ist = s_nxt.ist | {tc_evt, tx_buffer_empty_flag_evt};
        s_nxt.irq = |(s_nxt.ist & s_nxt.ien);

        // pin: general purpose unless the transmitter owns it
        if (s_nxt.st == SBT_TX_RUN) begin
            s_nxt.pin_oe = 1'b1;
        end else begin
            s_nxt.pin_o = s_nxt.ctrl[`SBT_CTRL_GPIO_OUT];
            s_nxt.pin_oe = s_nxt.ctrl[`SBT_CTRL_GPIO_DIR];
        end

        // read data captured in the wait cycle
        if (rd_acc) begin
            case (avs_address)
                `SBT_OFS_CTRL: s_nxt.rdata = {23'h0, s_r.ctrl};
                `SBT_OFS_STAT: s_nxt.rdata = {28'h0, shared_gpio_pin_i, s_r.st == SBT_TX_RUN, s_r.tc, s_r.tx_buffer_empty_flag};
                `SBT_OFS_ISTAT: s_nxt.rdata = {30'h0, s_r.ist};
                `SBT_OFS_IEN: s_nxt.rdata = {30'h0, s_r.ien};
                default: s_nxt.rdata = `SBT_RST_RDATA;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.ctrl <= `SBT_RST_CTRL;
            s_r.tx_hold <= `SBT_RST_HOLD;
            s_r.tx_buffer_empty_flag <= 1'b1;
            s_r.tx_buffer_empty_flag_pend <= 1'b0;
            s_r.tc <= 1'b1;
            s_r.st <= SBT_TX_GPIO;
            s_r.shreg <= `SBT_SHREG_ONES;
            s_r.bits_left <= 4'h0;
            s_r.pin_o <= 1'b0;
            s_r.pin_oe <= 1'b0;
            s_r.ist <= `SBT_RST_IRQ2;
            s_r.ien <= `SBT_RST_IRQ2;
            s_r.irq <= 1'b0;
            s_r.waitreq <= 1'b1;
            s_r.rdata <= `SBT_RST_RDATA;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = s_r.waitreq;
    assign shared_gpio_pin_o = s_r.pin_o;
    assign shared_gpio_pin_oe = s_r.pin_oe;
    assign irq = s_r.irq;

    // ****************************************
    // checks
    // ****************************************
    sequence s_take_pin;
        bi.bit_fall && s_r.ctrl[`SBT_CTRL_TE] && (s_r.st == SBT_TX_GPIO);
    endsequence

    sequence s_preamble_on;
        (s_r.st == SBT_TX_RUN) && s_r.pin_o && s_r.pin_oe && (s_r.bits_left == $past(flen) - 4'h1);
    endsequence

    sequence s_transfer;
        xfer && !data_wr;
    endsequence

    a_enable_sync: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(s_r.st == SBT_TX_RUN) |-> $past(bi.bit_fall))
        else $error("pin taken off a bit clock edge");

    a_preamble_start: assert property (@(posedge mclk) disable iff (!rst_n)
        s_take_pin |=> s_preamble_on)
        else $error("preamble did not start high with full length");

    a_pin_override: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_r.st == SBT_TX_RUN) |-> s_r.pin_oe)
        else $error("transmitter owns pin but does not drive it");

    a_gpio_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_r.st == SBT_TX_GPIO) |-> (s_r.pin_oe == s_r.ctrl[`SBT_CTRL_GPIO_DIR]))
        else $error("pin direction not general purpose before enable");

    a_frame_load: assert property (@(posedge mclk) disable iff (!rst_n)
        xfer |=> (s_r.shreg[0] == 1'b0) && (s_r.bits_left == $past(flen)))
        else $error("transferred frame lacks start bit or length");

    a_tx_buffer_empty_flag_delay: assert property (@(posedge mclk) disable iff (!rst_n)
        s_transfer |=> !s_r.tx_buffer_empty_flag ##[1:5] (s_r.tx_buffer_empty_flag || data_wr))
        else $error("buffer empty not set one bus tick after transfer");

    a_release_tc: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(s_r.st == SBT_TX_RUN) |-> s_r.tc && ($past(s_r.bits_left) == 4'h0))
        else $error("pin released mid character or without complete flag");

    a_write_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        data_wr |=> !s_r.tx_buffer_empty_flag && (s_r.tx_hold == $past(avs_writedata[8:0]))
            || ($past(avs_byteenable) != 4'hF))
        else $error("data write did not fill holding buffer");

    a_bit_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
        bi.bit_fall |=> (!bi.bit_fall) [*8])
        else $error("bit clock edges closer than minimum");

    a_wait_one: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_read || avs_write) && s_r.waitreq |=> !s_r.waitreq ##1 s_r.waitreq)
        else $error("waitrequest not released after one wait cycle");

    sequence s_stop_edge;
        bi.bit_fall && (s_r.st == SBT_TX_RUN) && (s_r.bits_left == 4'h1);
    endsequence

    sequence s_mid_char;
        (s_r.st == SBT_TX_RUN) && (s_r.bits_left != 4'h0);
    endsequence

    a_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
        s_r.irq == |(s_r.ist & s_r.ien))
        else $error("interrupt level does not follow enabled status");

    a_empty_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_buffer_empty_flag_evt |=> s_r.ist[0])
        else $error("buffer empty event not latched");

    a_done_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        tc_evt |=> s_r.ist[1])
        else $error("complete event not latched");

    a_stop_high: assert property (@(posedge mclk) disable iff (!rst_n)
        s_stop_edge |=> s_r.pin_o)
        else $error("last bit of frame not high");

    a_finish_char: assert property (@(posedge mclk) disable iff (!rst_n)
        s_mid_char |=> (s_r.st == SBT_TX_RUN))
        else $error("pin released before the frame ended");

    a_hold_steady: assert property (@(posedge mclk) disable iff (!rst_n)
        !data_wr |=> (s_r.tx_hold == $past(s_r.tx_hold)))
        else $error("holding buffer changed without a data write");

    a_data_unread: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_acc && (avs_address == `SBT_OFS_DATA) |=> (s_r.rdata == `SBT_RST_RDATA))
        else $error("write-only data register returned a value");

    a_gpio_value: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_r.st == SBT_TX_GPIO) |-> (s_r.pin_o == s_r.ctrl[`SBT_CTRL_GPIO_OUT]))
        else $error("pin value not general purpose before enable");

endmodule

`default_nettype wire

/* verif/sbt_serial_rx.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// remote receiver: two frames per enable
// ****************************************
module sbt_serial_rx (
    input wire logic mclk,
    input wire logic line,
    input wire logic oe,
    input wire logic [31:0] bit_c,
    input wire logic [31:0] nbits,
    output int pre_cyc,
    output logic [8:0] rx_data,
    output logic stop_ok,
    output int frames
);
    int k;
    int i;
    int bc;
    logic [8:0] d;
    initial begin
        frames = 0;
        pre_cyc = 0;
        rx_data = 9'h000;
        stop_ok = 1'b0;
        forever begin
            // let the previous stop bit end first, or its idle high rearms us
            while (oe === 1'b1 && line === 1'b1) @(posedge mclk);
            // pin high and driven marks the idle preamble start
            @(posedge mclk iff (oe === 1'b1 && line === 1'b1));
            bc = bit_c;
            pre_cyc = 0;
            do begin
                @(posedge mclk);
                pre_cyc++;
            end while (line === 1'b1);
            for (k = 0; k < 2; k++) begin
                while (line !== 1'b0) @(posedge mclk);
                repeat (bc / 2) @(posedge mclk);
                d = 9'h000;
                // lsb first after the start bit
                for (i = 0; i < nbits; i++) begin
                    repeat (bc) @(posedge mclk);
                    d[i] = line;
                end
                repeat (bc) @(posedge mclk);
                stop_ok = line;
                rx_data = d;
                frames++;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/sci_baud_and_tx_start_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defines.svh"
module sci_baud_and_tx_start_tb_top;
    import sbt_pkg::*;
    // short bus divide keeps the slowest rate inside the run
    localparam int XD = 1;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pin_o;
    logic pin_oe;
    logic irq;
    logic line;
    logic [31:0] bit_c = 32'h0000_0010;
    logic [31:0] nbits = 32'h0000_0008;
    int pre_cyc;
    logic [8:0] rx_data;
    logic stop_ok;
    int frames;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    // pull-up while nobody drives the pin
    assign line = pin_oe ? pin_o : 1'b1;
    always #50 mclk = ~mclk;

    sbt_top #(.XTAL_DIV(XD)) sbt_top_i (
        .mclk(mclk),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .shared_gpio_pin_i(line),
        .shared_gpio_pin_o(pin_o),
        .shared_gpio_pin_oe(pin_oe),
        .irq(irq)
    );
    sbt_serial_rx sbt_serial_rx_i (
        .mclk(mclk),
        .line(line),
        .oe(pin_oe),
        .bit_c(bit_c),
        .nbits(nbits),
        .pre_cyc(pre_cyc),
        .rx_data(rx_data),
        .stop_ok(stop_ok),
        .frames(frames)
    );

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic summarize;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp, input string what);
        num_checks++;
        if (got != exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 95000) begin
            miscompares++;
            $display("[FAIL] %0t run did not finish", $time);
            summarize();
        end
    end

    // ****************************************
    // register bus
    // ****************************************
    task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr_en;
        avs_read <= ~wr_en;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp, what);
    endtask
    function automatic int dv(input logic [1:0] p);
        case (p)
            2'h0: return 1;
            2'h1: return 3;
            2'h2: return 4;
            default: return 13;
        endcase
    endfunction

    // ****************************************
    // enable, two queued characters, disable mid character
    // ****************************************
    task automatic run_tx(input logic [1:0] pre, input logic [2:0] rate, input logic m,
                          input logic [1:0] gp, input logic [8:0] c0, input logic [8:0] c1);
        int bc;
        int f0;
        int t0;
        logic [31:0] ctrl;
        bc = dv(pre) * (1 << rate) * 16 * XD;
        f0 = frames;
        bit_c <= bc;
        nbits <= m ? 32'h0000_0009 : 32'h0000_0008;
        ctrl = {23'h0, gp, m, 1'b1, rate, pre};
        wr(`SBT_OFS_CTRL, ctrl);
        t0 = cyc;
        wr(`SBT_OFS_DATA, {23'h0, c0});
        bus(1'b0, `SBT_OFS_STAT, 32'h0000_0000);
        chk(rd[0], 1'b0, "buffer not full");
        while (!(pin_oe === 1'b1 && pin_o === 1'b1)) @(posedge mclk);
        chk_n(int'(cyc - t0 <= bc + 8), 1, "enable late");
        do bus(1'b0, `SBT_OFS_STAT, 32'h0000_0000); while (rd[0] !== 1'b1);
        chk(pin_o, 1'b1, "buffer freed after preamble");
        chk(rd[2], 1'b1, "pin not owned");
        wr(`SBT_OFS_DATA, {23'h0, c1});
        while (frames <= f0) @(posedge mclk);
        chk_n(pre_cyc, (m ? 11 : 10) * bc, "preamble length");
        chk(rx_data, c0, "first char");
        chk(stop_ok, 1'b1, "first stop");
        while (pin_o !== 1'b0) @(posedge mclk);
        wr(`SBT_OFS_CTRL, ctrl & 32'hFFFF_FFDF);
        while (frames <= f0 + 1) @(posedge mclk);
        chk(pin_oe, 1'b1, "released inside stop");
        chk(rx_data, c1, "second char");
        chk(stop_ok, 1'b1, "second stop");
        while (!(pin_oe === gp[1] && (pin_o === gp[0] || !gp[1]))) @(posedge mclk);
        bus(1'b0, `SBT_OFS_STAT, 32'h0000_0000);
        chk(rd[2:1], 2'h1, "complete and released");
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdc(`SBT_OFS_CTRL, 32'h0, "ctrl reset");
        rdc(`SBT_OFS_STAT, 32'hB, "stat reset");
        rdc(`SBT_OFS_ISTAT, 32'h0, "istat reset");
        rdc(`SBT_OFS_IEN, 32'h0, "ien reset");
        rdc(5'h18, 32'h0, "unmapped read");
        wr(`SBT_OFS_STAT, 32'hF);
        wr(5'h18, 32'h1FF);
        rdc(`SBT_OFS_STAT, 32'hB, "stat read only");
        wr(`SBT_OFS_CTRL, 32'h100);
        rdc(`SBT_OFS_CTRL, 32'h100, "ctrl readback");
        chk(pin_oe, 1'b1, "gpio dir");
        chk(pin_o, 1'b0, "gpio out");
        rdc(`SBT_OFS_STAT, 32'h3, "pin input");
        rdc(`SBT_OFS_DATA, 32'h0, "data write only");
        run_tx(2'h0, 3'h0, 1'b0, 2'h2, 9'h0A5, 9'h03C);
        rdc(`SBT_OFS_ISTAT, 32'h3, "events sticky");
        chk(irq, 1'b0, "masked irq");
        wr(`SBT_OFS_IEN, 32'h1);
        rdc(`SBT_OFS_IEN, 32'h1, "ien readback");
        chk(irq, 1'b1, "irq on");
        wr(`SBT_OFS_ICLR, 32'h1);
        rdc(`SBT_OFS_ISTAT, 32'h2, "clear one");
        chk(irq, 1'b0, "irq off");
        wr(`SBT_OFS_ICLR, 32'h2);
        rdc(`SBT_OFS_ISTAT, 32'h0, "clear all");
        run_tx(2'h1, 3'h0, 1'b0, 2'h0, 9'h0C3, 9'h055);
        run_tx(2'h2, 3'h0, 1'b1, 2'h0, 9'h1A5, 9'h15A);
        run_tx(2'h3, 3'h0, 1'b0, 2'h0, 9'h0FF, 9'h000);
        run_tx(2'h0, 3'h1, 1'b0, 2'h0, 9'h001, 9'h080);
        run_tx(2'h0, 3'h7, 1'b0, 2'h0, 9'h05A, 9'h0A5);
        summarize();
    end
endmodule
`default_nettype wire
